// ===== common/alc_defs.svh
`ifndef ALC_DEFS_SVH
`define ALC_DEFS_SVH

`define ALC_CODE_W     12
`define ALC_ADDR_W     12
`define ALC_ENTRY_W    16
`define ALC_FRAC_W     4
`define ALC_DIFF_W     18
`define ALC_CORES      4
`define ALC_CORE_W     2
`define ALC_ENTRIES    4096
`define ALC_FIFO_DEPTH 16
`define ALC_FIFO_CNT_W 5
`define ALC_PIPE_ROOM  5'h03
`define ALC_CODE_MAX   12'hFFF
`define ALC_CODE_ZERO  12'h000
`define ALC_ADDR_LAST  12'hFFF
`define ALC_ADDR_ZERO  12'h000
`define ALC_ENTRY_ZERO 16'h0000
`define ALC_CORE_A     2'h0
`define ALC_CORE_B     2'h1
`define ALC_CORE_C     2'h2
`define ALC_CORE_D     2'h3
`define ALC_MASK_A     4'h1
`define ALC_MASK_B     4'h2
`define ALC_MASK_C     4'h4
`define ALC_MASK_D     4'h8

`endif

// ===== common/alc_pkg.sv
`default_nettype none
`include "alc_defs.svh"

package alc_pkg;
    typedef logic [`ALC_CODE_W-1:0]  alc_code_t;
    typedef logic [`ALC_CORE_W-1:0]  alc_core_t;
    typedef logic [`ALC_CORES-1:0]   alc_mask_t;
    typedef logic signed [`ALC_ENTRY_W-1:0] alc_entry_t;
    typedef struct packed {
        alc_core_t core;
        alc_code_t code;
    } alc_word_t;
    typedef enum logic [1:0] {
        ALC_IDLE  = 2'b01,
        ALC_ERASE = 2'b10
    } alc_state_t;
endpackage

`default_nettype wire

// ===== common/alc_stream_if.sv
`default_nettype none
`include "alc_defs.svh"

interface alc_stream_if;
    import alc_pkg::*;
    alc_word_t             data;
    logic                  valid;
    logic                  ready;
    logic [`ALC_FIFO_CNT_W-1:0] level;
    modport src (output data, output valid, input ready, input level);
    modport snk (input data, input valid, output ready, output level);
endinterface

`default_nettype wire

// ===== logic/alc_fifo.sv
`default_nettype none
`include "alc_defs.svh"

module alc_fifo
    import alc_pkg::*;
#(
    parameter int WIDTH = $bits(alc_word_t),
    parameter int DEPTH = `ALC_FIFO_DEPTH
)
(
    input  wire logic  mclk_i,
    input  wire logic  reset_i,
    alc_stream_if.snk  push,
    alc_stream_if.src  pop
);
    // Shift-register storage keeps the head in a flip-flop at all times
    logic [WIDTH-1:0] slot [DEPTH];
    logic [DEPTH-1:0] vld;
    logic [`ALC_FIFO_CNT_W-1:0] count;
    logic do_push;
    logic do_pop;

    assign do_pop  = vld[0] && pop.ready;
    assign do_push = push.valid && !vld[DEPTH-1];
    assign push.ready = !vld[DEPTH-1];
    assign push.level = count;
    assign pop.valid  = vld[0];
    assign pop.data   = slot[0];

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            count <= '0;
        else if (do_push && !do_pop)
            count <= count + 1'b1;
        else if (do_pop && !do_push)
            count <= count - 1'b1;
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_slot
            logic [WIDTH-1:0] above;
            logic             above_v;
            logic             tail_here;
            if (i == DEPTH-1)
            begin : g_top
                assign above   = '0;
                assign above_v = 1'b0;
            end
            else
            begin : g_mid
                assign above   = slot[i+1];
                assign above_v = vld[i+1];
            end
            assign tail_here = do_push && (do_pop ?
                (count == (`ALC_FIFO_CNT_W)'(i + 1)) :
                (count == (`ALC_FIFO_CNT_W)'(i)));
            always_ff @(posedge mclk_i)
            begin
                if (reset_i)
                begin
                    vld[i]  <= 1'b0;
                    slot[i] <= '0;
                end
                else
                begin
                    if (tail_here)
                        slot[i] <= push.data;
                    else if (do_pop)
                        slot[i] <= above;
                    vld[i] <= tail_here || (do_pop ? above_v : vld[i]);
                end
            end
        end
    endgenerate

    fifo_order_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_pop && vld[1] |=> slot[0] == $past(slot[1]))
        else $error("fifo head did not advance");
endmodule

`default_nettype wire

// ===== logic/alc_corrector.sv
`default_nettype none
`include "alc_defs.svh"

// What this block does
// - Each sample code N has its table entry for N subtracted.
// - The difference is truncated to an integer 12-bit code.
// - Each table holds 4096 signed fractional entries, one per code.
// - Aligned operation keeps four tables, each used for its own core.
// - A single table is written to every core the host selects.
// - Once enabled, correction applies until the host disables it or resets the tables.
// - Disabling stops subtraction but keeps the stored tables.
// - Table reset stops correction and erases every table.
module alc_corrector
(
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    input  wire logic             sample_valid_i,
    input  wire alc_pkg::alc_core_t sample_core_i,
    input  wire alc_pkg::alc_code_t sample_code_i,
    output var  logic             sample_ready_o,
    output var  logic             out_valid_o,
    input  wire logic             out_ready_i,
    output var  alc_pkg::alc_core_t out_core_o,
    output var  alc_pkg::alc_code_t out_code_o,
    input  wire logic             load_valid_i,
    input  wire logic             load_col_mode_i,
    input  wire alc_pkg::alc_core_t load_col_i,
    input  wire alc_pkg::alc_mask_t load_mask_i,
    input  wire alc_pkg::alc_code_t load_addr_i,
    input  wire alc_pkg::alc_entry_t load_entry_i,
    input  wire logic             enable_set_i,
    input  wire logic             enable_clr_i,
    input  wire logic             table_reset_i,
    output var  logic             lut_enabled_o,
    output var  logic             erase_busy_o
);
    import alc_pkg::*;

    // Download column position to core: columns come as A, C, B, D
    function automatic alc_mask_t col_to_mask(input alc_core_t col);
        case (col)
            `ALC_CORE_A: col_to_mask = `ALC_MASK_A;
            `ALC_CORE_B: col_to_mask = `ALC_MASK_C;
            `ALC_CORE_C: col_to_mask = `ALC_MASK_B;
            default:     col_to_mask = `ALC_MASK_D;
        endcase
    endfunction

    // Clamp a fixed-point difference to a valid code, dropping the fraction
    function automatic alc_code_t clamp_code(
        input logic signed [`ALC_DIFF_W-1:0] d);
        logic signed [`ALC_DIFF_W-1:0] whole;
        whole = d >>> `ALC_FRAC_W;
        if (whole < 0)
            clamp_code = `ALC_CODE_ZERO;
        else if (whole > $signed({6'h00, `ALC_CODE_MAX}))
            clamp_code = `ALC_CODE_MAX;
        else
            clamp_code = whole[`ALC_CODE_W-1:0];
    endfunction

    alc_state_t state;
    logic [`ALC_ADDR_W-1:0] erase_addr;
    logic       lut_en;
    logic       take;
    logic       load_take;
    alc_mask_t  wr_mask;
    alc_code_t  wr_addr;
    alc_entry_t wr_data;
    alc_entry_t rd_entry [`ALC_CORES];
    logic       s1_valid;
    logic       s1_en;
    alc_core_t  s1_core;
    alc_code_t  s1_code;
    alc_entry_t s1_entry;
    logic signed [`ALC_DIFF_W-1:0] diff;
    logic       s2_valid;
    alc_word_t  s2_word;

    alc_stream_if fin ();
    alc_stream_if fout ();

    assign take      = sample_valid_i && sample_ready_o;
    // Loads are dropped while erasing so a reset always leaves clean tables
    assign load_take = load_valid_i && (state == ALC_IDLE);

    always_comb
    begin
        if (state == ALC_ERASE)
        begin
            wr_mask = '1;
            wr_addr = erase_addr;
            wr_data = `ALC_ENTRY_ZERO;
        end
        else
        begin
            wr_mask = load_take ? (load_col_mode_i ? col_to_mask(load_col_i)
                                                   : load_mask_i) : '0;
            wr_addr = load_addr_i;
            wr_data = load_entry_i;
        end
    end

    // One table per core, each with a registered read of the sample's code
    genvar c;
    generate
        for (c = 0; c < `ALC_CORES; c++)
        begin : g_tab
            alc_entry_t mem [`ALC_ENTRIES];
            always_ff @(posedge mclk_i)
            begin
                if (wr_mask[c])
                    mem[wr_addr] <= wr_data;
                rd_entry[c] <= mem[sample_code_i];
            end
        end
    endgenerate

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            state      <= ALC_ERASE;
            erase_addr <= `ALC_ADDR_ZERO;
        end
        else
        begin
            case (state)
                ALC_IDLE:
                begin
                    if (table_reset_i)
                        state <= ALC_ERASE;
                    erase_addr <= `ALC_ADDR_ZERO;
                end
                ALC_ERASE:
                begin
                    erase_addr <= erase_addr + 1'b1;
                    // A reset on the last address of the sweep runs it once more; earlier in the sweep it has no effect
                    if (erase_addr == `ALC_ADDR_LAST && !table_reset_i)
                        state <= ALC_IDLE;
                end
                default:
                    state <= ALC_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            lut_en <= 1'b0;
        else if (table_reset_i || state == ALC_ERASE)
            lut_en <= 1'b0;
        else if (enable_clr_i)
            lut_en <= 1'b0;
        else if (enable_set_i)
            lut_en <= 1'b1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            s1_valid <= 1'b0;
            s1_en    <= 1'b0;
            s1_core  <= `ALC_CORE_A;
            s1_code  <= `ALC_CODE_ZERO;
        end
        else
        begin
            s1_valid <= take;
            s1_en    <= lut_en;
            s1_core  <= sample_core_i;
            s1_code  <= sample_code_i;
        end
    end

    assign s1_entry = rd_entry[s1_core];
    assign diff = $signed({2'b00, s1_code, {`ALC_FRAC_W{1'b0}}})
                - (`ALC_DIFF_W)'(s1_entry);

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            s2_valid <= 1'b0;
            s2_word  <= '0;
        end
        else
        begin
            s2_valid     <= s1_valid;
            s2_word.core <= s1_core;
            s2_word.code <= s1_en ? clamp_code(diff)
                                  : s1_code;
        end
    end

    // Ready is registered, so it reserves room for four samples: the two stages and two more takes
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            sample_ready_o <= 1'b0;
        else
            sample_ready_o <= (`ALC_FIFO_CNT_W)'(`ALC_FIFO_DEPTH) - fin.level
                              > `ALC_PIPE_ROOM;
    end

    assign fin.data  = s2_word;
    assign fin.valid = s2_valid;
    assign fout.ready = out_ready_i;
    assign fout.level = '0;

    alc_fifo #(
        .WIDTH ($bits(alc_word_t)),
        .DEPTH (`ALC_FIFO_DEPTH)
    ) u_fifo (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .push    (fin),
        .pop     (fout)
    );

    assign out_valid_o   = fout.valid;
    assign out_core_o    = fout.data.core;
    assign out_code_o    = fout.data.code;
    assign lut_enabled_o = lut_en;
    assign erase_busy_o  = (state == ALC_ERASE);

    corr_value_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        s1_valid && s1_en && diff >= 0 && diff < 18'sh10000
        |=> s2_word.code == $past(diff[15:4]))
        else $error("corrected code does not match the table entry");
    trunc_floor_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        s1_valid && s1_en && diff >= 18'sh10 && diff < 18'sh10000
        |=> {1'b0, s2_word.code} < {1'b0, $past(s1_code)} + 13'h0001
            || $past(s1_entry) < 0)
        else $error("truncation rounded upward");
    clamp_low_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        s1_valid && s1_en && diff < 0 |=> s2_word.code == 12'h000)
        else $error("negative result not clamped to zero");
    bypass_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        s1_valid && !s1_en |=> s2_word.code == $past(s1_code))
        else $error("code altered while correction is off");
    enable_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        lut_en && !enable_clr_i && !table_reset_i && state == ALC_IDLE
        |=> lut_en)
        else $error("correction dropped without disable");
    reset_stop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        table_reset_i |=> !lut_en && state == ALC_ERASE)
        else $error("table reset did not stop and erase");
    erase_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        state == ALC_ERASE |-> wr_mask == 4'hF && wr_data == 16'h0000
        ##1 (erase_addr == $past(erase_addr) + 12'h001))
        else $error("erase sweep is not writing zeros");
    keep_tables_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        enable_clr_i && !load_valid_i && state == ALC_IDLE
        |-> wr_mask == 4'h0)
        else $error("disable touched the tables");
    core_select_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        take ##1 s1_valid |-> s1_core == $past(sample_core_i)
            && s1_code == $past(sample_code_i))
        else $error("sample read from the wrong table or code");
    col_order_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        load_take && load_col_mode_i && load_col_i == 2'h1
        |-> wr_mask == 4'h4)
        else $error("second column not routed to core C");

    cov_corrected_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        s1_valid && s1_en ##1 s2_valid);
    cov_fifo_full_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        !fin.ready);
    cov_reset_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        lut_en ##1 table_reset_i);
endmodule

`default_nettype wire

// ===== sim/alc_sink_model.sv
`default_nettype none

module alc_sink_model
    import alc_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               reset_i,
    input  wire logic               stall_i,
    input  wire logic               out_valid_i,
    input  wire alc_pkg::alc_core_t out_core_i,
    input  wire alc_pkg::alc_code_t out_code_i,
    output var  logic               out_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;

    alc_word_t  got_q[$];
    logic [1:0] beat;

    initial out_ready_o = 1'b0;

    // Slow sink: one beat in four is refused even when not stalled
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            beat        <= 2'h0;
            out_ready_o <= 1'b0;
        end
        else
        begin
            beat        <= beat + 2'h1;
            out_ready_o <= !stall_i && (beat != 2'h3);
            if (out_valid_i && out_ready_o)
                got_q.push_back({out_core_i, out_code_i});
        end
    end
endmodule

`default_nettype wire

// ===== sim/adc_lut_linearity_corrector_test.sv
`default_nettype none

`define ALC_CHECK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module adc_lut_linearity_corrector_test;
    import alc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i, reset_i, sample_valid_i, sample_ready_o, out_valid_o;
    logic out_ready, load_valid_i, load_col_mode_i, enable_set_i;
    logic enable_clr_i, table_reset_i, lut_enabled_o, erase_busy_o, stall;
    alc_core_t  sample_core_i, out_core_o, load_col_i;
    alc_code_t  sample_code_i, out_code_o, load_addr_i;
    alc_mask_t  load_mask_i;
    alc_entry_t load_entry_i;
    alc_word_t  exp_q[$];
    int         bad_count, cmp_count, cycles;

    alc_corrector dut (.mclk_i(mclk_i), .reset_i(reset_i),
        .sample_valid_i(sample_valid_i), .sample_core_i(sample_core_i),
        .sample_code_i(sample_code_i), .sample_ready_o(sample_ready_o),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready),
        .out_core_o(out_core_o), .out_code_o(out_code_o),
        .load_valid_i(load_valid_i), .load_col_mode_i(load_col_mode_i),
        .load_col_i(load_col_i), .load_mask_i(load_mask_i),
        .load_addr_i(load_addr_i), .load_entry_i(load_entry_i),
        .enable_set_i(enable_set_i), .enable_clr_i(enable_clr_i),
        .table_reset_i(table_reset_i), .lut_enabled_o(lut_enabled_o),
        .erase_busy_o(erase_busy_o));

    alc_sink_model sink (.mclk_i(mclk_i), .reset_i(reset_i),
        .stall_i(stall), .out_valid_i(out_valid_o), .out_core_i(out_core_o),
        .out_code_i(out_code_o), .out_ready_o(out_ready));

    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Ceiling well above two erase sweeps plus traffic
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    task automatic pulse(ref logic s);
        @(negedge mclk_i) s = 1'b1;
        @(negedge mclk_i) s = 1'b0;
    endtask

    task automatic wait_erase();
        int i;
        for (i = 0; i < 5000 && erase_busy_o !== 1'b0; i++)
            @(posedge mclk_i);
        `ALC_CHECK(erase_busy_o, 1'b0)
    endtask

    // Host download of one entry; column mode or mask mode
    task automatic load(logic cm, alc_core_t col, alc_mask_t m,
                        alc_code_t a, alc_entry_t e);
        @(negedge mclk_i);
        load_valid_i    = 1'b1;
        load_col_mode_i = cm;
        load_col_i      = col;
        load_mask_i     = m;
        load_addr_i     = a;
        load_entry_i    = e;
        @(negedge mclk_i) load_valid_i = 1'b0;
    endtask

    task automatic send(alc_core_t c, alc_code_t n, alc_code_t exp_n);
        int i;
        @(negedge mclk_i);
        sample_valid_i = 1'b1;
        sample_core_i  = c;
        sample_code_i  = n;
        i = 0;
        // Ready only moves on the rising edge, so the falling edge sees it
        while (sample_ready_o !== 1'b1 && i < 300)
        begin
            @(negedge mclk_i);
            i++;
        end
        if (i >= 300)
            bad_count++;
        @(negedge mclk_i);
        exp_q.push_back({c, exp_n});
        sample_valid_i = 1'b0;
    endtask

    task automatic check_out();
        int i;
        alc_word_t g;
        alc_word_t e;
        for (i = 0; i < 500 && sink.got_q.size() < exp_q.size(); i++)
            @(posedge mclk_i);
        `ALC_CHECK(sink.got_q.size(), exp_q.size())
        // Pop once: the check macro reads its arguments twice
        while (exp_q.size() > 0 && sink.got_q.size() > 0)
        begin
            g = sink.got_q.pop_front();
            e = exp_q.pop_front();
            `ALC_CHECK(g, e)
        end
        exp_q.delete();
        sink.got_q.delete();
    endtask

    initial
    begin
        {sample_valid_i, load_valid_i, load_col_mode_i, enable_set_i} = '0;
        {enable_clr_i, table_reset_i, stall} = '0;
        {sample_core_i, sample_code_i, load_col_i, load_mask_i} = '0;
        {load_addr_i, load_entry_i, bad_count, cmp_count, cycles} = '0;
        reset_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        reset_i = 1'b0;
        @(negedge mclk_i);
        `ALC_CHECK(lut_enabled_o, 1'b0)
        `ALC_CHECK(erase_busy_o, 1'b1)
        wait_erase();
        send(2'h0, 12'hC88, 12'hC88);
        // Single table to all four cores; 25/16 LSB at code 3208
        load(1'b0, 2'h0, 4'hF, 12'hC88, 16'sh0019);
        load(1'b0, 2'h0, 4'hF, 12'hFFF, -16'sh0020);
        load(1'b0, 2'h0, 4'hF, 12'h000, 16'sh0010);
        load(1'b0, 2'h0, 4'hF, 12'h00A, -16'sh0008);
        // Column order A, C, B, D with corrections 1, 2, 3, 4 LSB
        for (int k = 0; k < 4; k++)
            load(1'b1, 2'(k), 4'h0, 12'h064, 16'(16 * (k + 1)));
        pulse(enable_set_i);
        `ALC_CHECK(lut_enabled_o, 1'b1)
        for (int k = 0; k < 4; k++)
            send(2'(k), 12'hC88, 12'hC86);
        send(2'h0, 12'h064, 12'h063);
        send(2'h1, 12'h064, 12'h061);
        send(2'h2, 12'h064, 12'h062);
        send(2'h3, 12'h064, 12'h060);
        send(2'h1, 12'hFFF, 12'hFFF);
        send(2'h2, 12'h000, 12'h000);
        send(2'h3, 12'h00A, 12'h00A);
        check_out();
        pulse(enable_clr_i);
        `ALC_CHECK(lut_enabled_o, 1'b0)
        send(2'h3, 12'h064, 12'h064);
        pulse(enable_set_i);
        send(2'h3, 12'h064, 12'h060);
        check_out();
        // Back the FIFO up against a stalled sink until ready drops, then drain it in order
        @(negedge mclk_i) stall = 1'b1;
        fork
            for (int k = 0; k < 20; k++)
                send(2'(k), 12'(12'h200 + k), 12'(12'h200 + k));
            begin
                repeat (60) @(negedge mclk_i);
                `ALC_CHECK(sample_ready_o, 1'b0)
                stall = 1'b0;
            end
        join
        check_out();
        pulse(table_reset_i);
        `ALC_CHECK(lut_enabled_o, 1'b0)
        `ALC_CHECK(erase_busy_o, 1'b1)
        wait_erase();
        pulse(enable_set_i);
        send(2'h3, 12'h064, 12'h064);
        send(2'h0, 12'hC88, 12'hC88);
        check_out();
        finish_test();
    end
endmodule

`default_nettype wire
